// [rtl/standby_defs.svh]
// Purpose: Constants for the standby control block
// Assumes: core_clk at 250 MHz
// Notes:   Types live in standby_pkg
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
`define CLK_PERIOD_NS      4
`define MACHINE_CYCLE_NS   2500
`define MCYC_CLKS          ((`MACHINE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_MCYCLES      5
`define RESET_VECTOR       12'h000
`define INT_WINDOW_MCYC    1
`endif

// [rtl/standby_pkg.sv]
// Purpose: Types for the standby control block
// Assumes: Nothing
// Notes:   One-hot state codes
package standby_pkg;
	typedef enum logic [4:0] {
		ST_RESET = 5'b0_0001,
		ST_RUN   = 5'b0_0010,
		ST_HALT  = 5'b0_0100,
		ST_STOP  = 5'b0_1000,
		ST_WAKE  = 5'b1_0000
	} standby_state_t;
endpackage

// [rtl/sync_two_ff.sv]
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Asynchronous pins
// Notes:   Stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff #(
	parameter int        WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1   <= INIT;
			sync_out <= INIT;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// [rtl/standby_halt_stop_control.sv]
// Purpose: Halt and Stop standby control of a small 8-bit microcomputer core
// Assumes: core_clk is the free-running oscillator clock; pins are asynchronous
// Notes:   cpu_clk_en gates the processor clock; pin reset is reset_pin_n
//
// How it works
// - Halt keeps oscillator, gates processor clock
// - Halt freezes all processor state
// - Halt entered by instruction; left by interrupt/reset
// - Enabled interrupt wakes, vectors after instructions
// - Disabled interrupt wakes, continues after halt
// - Interrupt accepted just before halt runs first
// - Reset in halt restarts at address 0
// - Stop halts oscillator, keeps only RAM
// - Reset release after stable; start at 0
// - Reset lasts at least five machine cycles
// - Control high restarts oscillator
// - Any reset disables external interrupt
`timescale 1ns/10ps
`default_nettype none
`include "standby_defs.svh"

module standby_halt_stop_control #(
	parameter int RESET_MCYC = `RESET_MCYCLES,
	parameter int MCYC       = `MCYC_CLKS
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        reset_pin_n,
	input  wire logic        int_pin_n,
	input  wire logic        osc_run_ctrl,
	input  wire logic        halt_exec,
	input  wire logic        int_enable_set,
	input  wire logic        int_enable_clr,
	input  wire logic        irq_accepted,
	output logic             cpu_clk_en,
	output logic             osc_enable,
	output logic             cpu_reset,
	output logic             ram_retain,
	output logic             int_enabled,
	output logic             wake_take_int,
	output logic             wake_pulse,
	output logic             reset_done,
	output logic             bus_unstable,
	output logic      [11:0] start_address
);
	if (RESET_MCYC < 1 || RESET_MCYC > 255 || MCYC < 1 || MCYC > 65535) begin : gen_bad_params
		$error("standby_halt_stop_control: unsupported parameter values");
	end

	standby_pkg::standby_state_t state;
	standby_pkg::standby_state_t next_state;
	logic [2:0]  sync_out;
	logic        rst_pin_s;
	logic        int_pin_s;
	logic        osc_ctrl_s;
	logic [15:0] clk_cnt;
	logic [7:0]  mcyc_cnt;
	logic [15:0] pre_halt_cnt;
	logic [15:0] window_load;
	logic        pending_int;

	// Pin inputs pass two flops on the free-running clock
	sync_two_ff #(
		.WIDTH (3),
		.INIT  (3'b110)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in ({osc_run_ctrl, int_pin_n, reset_pin_n}),
		.sync_out (sync_out)
	);

	assign rst_pin_s  = sync_out[0];
	assign int_pin_s  = sync_out[1];
	assign osc_ctrl_s = sync_out[2];

	wire mcyc_tick   = (clk_cnt == 16'(MCYC - 1));
	wire rst_long    = (mcyc_cnt >= 8'(RESET_MCYC));
	wire stop_req    = !rst_pin_s && !osc_ctrl_s;
	wire int_wake    = !int_pin_s;
	wire late_accept = irq_accepted || (pre_halt_cnt != 16'h0000);
	wire in_reset    = (state == standby_pkg::ST_RESET);

	// Next-state decodes shared by the output registers
	wire next_is_reset = (next_state == standby_pkg::ST_RESET);
	wire next_is_run   = (next_state == standby_pkg::ST_RUN);
	wire next_is_stop  = (next_state == standby_pkg::ST_STOP);
	wire next_is_wake  = (next_state == standby_pkg::ST_WAKE);
	wire take_vector   = next_is_wake && (int_enabled || pending_int);
	wire reset_aged    = in_reset && rst_long;
	wire early_stop    = in_reset && !rst_long && !osc_ctrl_s;

	// One full machine cycle of look-back for an interrupt accepted before halt
	assign window_load = 16'(`INT_WINDOW_MCYC * MCYC);

	// State transitions
	always_comb begin
		next_state = state;
		case (state)
			standby_pkg::ST_RESET: begin
				if (stop_req && rst_long)
					next_state = standby_pkg::ST_STOP;
				else if (rst_pin_s && rst_long)
					next_state = standby_pkg::ST_RUN;
			end
			standby_pkg::ST_RUN: begin
				if (!rst_pin_s)
					next_state = standby_pkg::ST_RESET;
				else if (halt_exec)
					next_state = standby_pkg::ST_HALT;
			end
			standby_pkg::ST_HALT: begin
				if (!rst_pin_s)
					next_state = standby_pkg::ST_RESET;
				else if (int_wake)
					next_state = standby_pkg::ST_WAKE;
			end
			standby_pkg::ST_STOP: begin
				if (osc_ctrl_s)
					next_state = standby_pkg::ST_RESET;
			end
			standby_pkg::ST_WAKE: begin
				next_state = standby_pkg::ST_RUN;
			end
			default: next_state = standby_pkg::ST_RESET;
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			state <= standby_pkg::ST_RESET;
		else
			state <= next_state;
	end

	// Machine-cycle timer; the count runs only in ST_RESET and is cleared in every other state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_cnt  <= 16'h0000;
			mcyc_cnt <= 8'h00;
		end else if (!in_reset || state == standby_pkg::ST_STOP) begin
			clk_cnt  <= 16'h0000;
			mcyc_cnt <= 8'h00;
		end else begin
			clk_cnt <= mcyc_tick ? 16'h0000 : clk_cnt + 16'h0001;
			if (mcyc_tick && !rst_long)
				mcyc_cnt <= mcyc_cnt + 8'h01;
		end
	end

	// Interrupt accepted within one machine cycle before halt stays pending
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_halt_cnt <= 16'h0000;
			pending_int  <= 1'b0;
		end else begin
			if (irq_accepted)
				pre_halt_cnt <= window_load;
			else if (pre_halt_cnt != 16'h0000)
				pre_halt_cnt <= pre_halt_cnt - 16'h0001;
			if (in_reset)
				pending_int <= 1'b0;
			else if (state == standby_pkg::ST_RUN && halt_exec && late_accept)
				pending_int <= 1'b1;
			else if (state == standby_pkg::ST_WAKE)
				pending_int <= 1'b0;
		end
	end

	// Interrupt enable; cleared on the same edge that raises cpu_reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			int_enabled <= 1'b0;
		else if (next_is_reset || next_is_stop)
			int_enabled <= 1'b0;
		else if (int_enable_set)
			int_enabled <= 1'b1;
		else if (int_enable_clr)
			int_enabled <= 1'b0;
	end

	// Processor clock gate and wake pulses
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_pulse    <= 1'h0;
			wake_take_int <= 1'h0;
			cpu_clk_en    <= 1'h0;
		end else begin
			wake_pulse    <= next_is_wake;
			wake_take_int <= take_vector;
			cpu_clk_en    <= next_is_run || next_is_wake;
		end
	end

	// Oscillator, core reset and RAM hold
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_enable    <= 1'h1;
			cpu_reset     <= 1'h1;
			ram_retain    <= 1'h0;
		end else begin
			osc_enable    <= !next_is_stop;
			cpu_reset     <= next_is_reset || next_is_stop;
			ram_retain    <= next_is_stop;
		end
	end

	// Reset status and start address
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_done    <= 1'h0;
			bus_unstable  <= 1'h0;
			start_address <= `RESET_VECTOR;
		end else begin
			reset_done    <= reset_aged;
			bus_unstable  <= early_stop;
			start_address <= `RESET_VECTOR;
		end
	end
endmodule
`default_nettype wire

// [dv/standby_chk.sv]
// Purpose: Port checker
// Assumes: One clock
// Notes:   Bound below
`timescale 1ns/10ps
`default_nettype none
module standby_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic int_pin_n,
	input wire logic osc_run_ctrl,
	input wire logic halt_exec,
	input wire logic cpu_clk_en,
	input wire logic osc_enable,
	input wire logic cpu_reset,
	input wire logic ram_retain,
	input wire logic int_enabled,
	input wire logic wake_take_int,
	input wire logic wake_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_wake;
		wake_pulse ##1 !wake_pulse;
	endsequence
	a_stop_state: assert property (!osc_enable |-> ram_retain && cpu_reset) else $error("stop");
	a_halt_gate: assert property (halt_exec && cpu_clk_en |=> !cpu_clk_en) else $error("gate");
	a_wake_once: assert property (wake_pulse |-> s_wake) else $error("pulse");
	a_wake_clk: assert property (wake_pulse |-> cpu_clk_en) else $error("clk");
	a_take_int: assert property (wake_take_int |-> wake_pulse && int_enabled) else $error("take");
	a_reset_ien: assert property (cpu_reset |-> !int_enabled) else $error("ien");
	a_wake_cause: assert property (wake_pulse |-> !$past(int_pin_n, 3)) else $error("cause");
	a_stop_cause: assert property ($fell(osc_enable) |-> !$past(osc_run_ctrl, 3)) else $error("osc");
endmodule
bind standby_halt_stop_control standby_chk i_standby_chk (
	.core_clk      (core_clk),
	.reset_n       (reset_n),
	.int_pin_n     (int_pin_n),
	.osc_run_ctrl  (osc_run_ctrl),
	.halt_exec     (halt_exec),
	.cpu_clk_en    (cpu_clk_en),
	.osc_enable    (osc_enable),
	.cpu_reset     (cpu_reset),
	.ram_retain    (ram_retain),
	.int_enabled   (int_enabled),
	.wake_take_int (wake_take_int),
	.wake_pulse    (wake_pulse)
);
`default_nettype wire

// [dv/standby_partner.sv]
// Purpose: Supply, reset and interrupt source
// Assumes: Pins move after core_clk rises
// Notes:   main_supply low is standby level
`timescale 1ns/10ps
`default_nettype none
module standby_partner (
	input  wire logic core_clk,
	output var logic  reset_pin_n,
	output var logic  int_pin_n,
	output var logic  osc_run_ctrl,
	output var logic  main_supply
);
	initial {reset_pin_n, int_pin_n, osc_run_ctrl, main_supply} = 4'hf;
	task automatic pulse_int();
		@(posedge core_clk) int_pin_n <= 1'h0;
		repeat (8) @(posedge core_clk);
		int_pin_n <= 1'h1;
	endtask
	task automatic enter(int hold, logic stop);
		@(posedge core_clk) reset_pin_n <= 1'h0;
		repeat (hold) @(posedge core_clk);
		{osc_run_ctrl, main_supply} <= {2{!stop}};
		repeat (8) @(posedge core_clk);
	endtask
	task automatic leave();
		@(posedge core_clk) main_supply <= 1'h1;
		repeat (4) @(posedge core_clk);
		osc_run_ctrl <= 1'h1;
		repeat (40) @(posedge core_clk);
		reset_pin_n <= 1'h1;
	endtask
endmodule
`default_nettype wire

// [dv/standby_halt_stop_control_test.sv]
// Purpose: Bench
// Assumes: MCYC is 4
// Notes:   Partner drives pins
`timescale 1ns/10ps
`default_nettype none
module standby_halt_stop_control_test;
	logic core_clk = 1'h0;
	logic reset_n, halt_exec, int_enable_set, int_enable_clr, irq_accepted;
	wire logic reset_pin_n, int_pin_n, osc_run_ctrl, main_supply, cpu_clk_en;
	wire logic osc_enable, cpu_reset, ram_retain, int_enabled, wake_take_int;
	wire logic wake_pulse, reset_done, bus_unstable;
	wire logic [11:0] start_address;
	int mismatches = 0;
	int num_checks = 0;
	always #2 core_clk = ~core_clk;
	standby_partner i_standby_partner (.*);
	standby_halt_stop_control #(.MCYC(4)) i_standby_halt_stop_control (.*);
	task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic core(logic [3:0] v);
		@(posedge core_clk) {halt_exec, int_enable_set, int_enable_clr, irq_accepted} <= v;
		@(posedge core_clk) {halt_exec, int_enable_set, int_enable_clr, irq_accepted} <= 4'h0;
	endtask
	task automatic wait_run();
		int n = 0;
		while (cpu_clk_en !== 1'h1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		check("run", cpu_clk_en, 1'h1);
		check("osc", osc_enable, 1'h1);
		check("addr", start_address, 12'h000);
	endtask
	task automatic t_halt_int(logic en);
		int n = 0;
		core({1'h0, en, !en, en});
		core(4'h8);
		repeat (2) @(negedge core_clk);
		check("gate", cpu_clk_en, 1'h0);
		repeat (6) @(negedge core_clk);
		check("hold", cpu_clk_en, 1'h0);
		fork
			i_standby_partner.pulse_int();
		join_none
		while (wake_pulse !== 1'h1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		check("take", {wake_pulse, wake_take_int, cpu_clk_en}, {1'h1, en, 1'h1});
		repeat (10) @(negedge core_clk);
	endtask
	task automatic t_halt_reset();
		core(4'h4);
		core(4'h8);
		fork
			i_standby_partner.enter(30, 1'h0);
			begin
				repeat (12) @(negedge core_clk);
				check("rst", {cpu_reset, int_enabled, reset_done}, 3'h4);
			end
		join
		check("done", reset_done, 1'h1);
		i_standby_partner.leave();
		wait_run();
	endtask
	task automatic t_stop(int hold, logic early);
		i_standby_partner.enter(hold, 1'h1);
		@(negedge core_clk);
		if (early) check("unst", bus_unstable, 1'h1);
		else check("stop", {osc_enable, ram_retain, bus_unstable}, 3'h2);
		i_standby_partner.leave();
		wait_run();
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{reset_n, halt_exec, int_enable_set, int_enable_clr, irq_accepted} = 5'h00;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'h1;
		wait_run();
		t_halt_int(1'h1);
		t_halt_int(1'h0);
		t_halt_reset();
		t_stop(30, 1'h0);
		t_stop(2, 1'h1);
		stop_test();
	end
	initial begin
		#40000;
		mismatches++;
		stop_test();
	end
endmodule
`default_nettype wire
